// File: hpm_pkg.sv
// package for the haptic playback mode control block
// assumes both ends share one clock (CLK_I, 50 MHz) and one synchronous reset
package hpm_pkg;
	// register offsets
	localparam logic [7:0] OFS_MODE  = 8'h01;
	localparam logic [7:0] OFS_AMP   = 8'h02;
	localparam logic [7:0] OFS_SLOT0 = 8'h04;
	localparam logic [7:0] OFS_SLOT7 = 8'h0b;
	localparam logic [7:0] OFS_START = 8'h0c;
	localparam logic [7:0] OFS_CFG   = 8'h1d;
	// controller registers of its own (software side)
	localparam logic [3:0] CTL_ADR_CMD    = 4'h0;
	localparam logic [3:0] CTL_ADR_STATUS = 4'h1;
	// field positions
	localparam int MODE_STBY_BIT = 6;
	localparam int CFG_ANALOG_BIT = 1;
	localparam int START_BIT = 0;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h40;
	localparam logic [7:0] ZERO8    = 8'h00;
	// mode field codes
	localparam logic [2:0] MD_SOFT  = 3'h0;
	localparam logic [2:0] MD_EDGE  = 3'h1;
	localparam logic [2:0] MD_LEVEL = 3'h2;
	localparam logic [2:0] MD_EXT   = 3'h3;
	localparam logic [2:0] MD_RT    = 3'h5;
	// timing: power-up wait and one effect playing time
	localparam int CLK_MHZ = 50;
	localparam int PWRUP_US = 250;
	localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
	localparam int EFFECT_CYC = 16;
	localparam int NSLOT = 8;
	typedef enum logic [1:0] {HPM_IDLE, HPM_PLAY} hpm_play_t;
endpackage : hpm_pkg

// File: hpm_if.sv
// link between controller (host) and haptic driver (device)
// assumes one common clock; register port is a simple strobe bus
`timescale 1ns/1ps
interface hpm_if;
	logic       en;        // enable pin, active high
	logic       trig;      // input/trigger pin level
	logic [7:0] addr;      // register address
	logic [7:0] wdata;     // write data
	logic       wr;        // write strobe
	logic       rd;        // read strobe
	logic [7:0] rdata;     // read data, cycle after rd
	logic       wvalid;    // buffered write offer
	logic       wready;    // device accepts writes
	modport dev  (input en, trig, addr, wdata, wr, rd, wvalid, output rdata, wready);
	modport host (output en, trig, addr, wdata, wr, rd, wvalid, input rdata, wready);
endinterface : hpm_if

// File: hpm_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes common clock and synchronous active-low reset
`timescale 1ns/1ps
module hpm_buf2 #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	typedef struct packed {
		logic [W-1:0] d0;   // head entry
		logic [W-1:0] d1;   // second entry
		logic [1:0]   cnt;  // fill level
	} hpm_buf_t;
	hpm_buf_t st_ff, nxt_st;
	logic push, pop;
	assign in_ready_o  = (st_ff.cnt != 2'd2);
	assign out_valid_o = (st_ff.cnt != 2'd0);
	assign out_data_o  = st_ff.d0;
	assign push = in_valid_i && in_ready_o;
	assign pop  = out_valid_o && out_ready_i;
	// next-state of the buffer
	always_comb
	begin
		nxt_st = st_ff;
		if (pop)
		begin
			nxt_st.d0 = st_ff.d1;
		end
		if (push)
		begin
			if ((st_ff.cnt == 2'd0) || (st_ff.cnt == 2'd1 && pop))
				nxt_st.d0 = in_data_i;
			else
				nxt_st.d1 = in_data_i;
		end
		nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
	end
	// state register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_ff <= '0;   // empty buffer
		else
			st_ff <= nxt_st;
	end
endmodule : hpm_buf2

// File: hpm_dev.sv
// haptic driver end: register bank, trigger and playback sequencer
// assumes registers written through the link; host keeps power-up wait
`timescale 1ns/1ps
module hpm_dev
	import hpm_pkg::*;
#(
	parameter int EFF_CYC = EFFECT_CYC
) (
	// clock and reset
	input  wire logic CLK_I,
	input  wire logic RESETN_I,
	// link
	hpm_if.dev        LNK,
	// actuator side
	output logic [7:0] DRIVE_O,      // drive amplitude or effect id
	output logic       ACTIVE_O,     // drive in progress
	output logic       LOW_POWER_O,  // low power state
	output logic       ANALOG_O      // external input read as analog
);
	////////////////////////////////////////////////////////////////////////
	// whole state of the device end in one record
	typedef struct packed {
		logic [7:0]            mode;    // mode select, standby in bit 6
		logic [7:0]            amp;     // realtime amplitude
		logic [7:0]            cfg;     // input source config
		logic [NSLOT-1:0][7:0] slot;    // effect sequence slots
		hpm_play_t             play;    // sequencer idle or playing
		logic [2:0]            idx;     // slot now playing
		logic [15:0]           tcnt;    // cycles left in this slot
		logic                  trig_q;  // trigger pin one cycle ago
		logic [7:0]            rdata;   // read data for the link
		logic [7:0]            drive;   // drive value toward actuator
		logic                  active;  // drive in progress
		logic                  lowp;    // low power state
	} hpm_dev_t;
	hpm_dev_t st_ff;      // registered state
	hpm_dev_t nxt_st;     // next state
	logic     lowp;       // enable low or standby set
	logic     fire;       // trigger accepted this cycle
	logic     trig_rise;  // rising edge on the trigger pin
	logic     wr_ok;      // qualified register write
	////////////////////////////////////////////////////////////////////////
	// true for an address inside the effect slot range
	function automatic logic is_slot(input logic [7:0] a);
		return (a >= OFS_SLOT0) && (a <= OFS_SLOT7);
	endfunction : is_slot
	// slot number of an address inside the slot range
	function automatic logic [2:0] slot_of(input logic [7:0] a);
		logic [7:0] d;  // offset from the first slot
		d = a - OFS_SLOT0;
		return d[2:0];
	endfunction : slot_of
	assign LNK.rdata   = st_ff.rdata;
	assign LNK.wready  = 1'b1;
	assign DRIVE_O     = st_ff.drive;
	assign ACTIVE_O    = st_ff.active;
	assign LOW_POWER_O = st_ff.lowp;
	assign ANALOG_O    = st_ff.cfg[CFG_ANALOG_BIT];
	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		// start from the held state
		nxt_st = st_ff;
		// low power while the pin is low or standby is set
		lowp = !LNK.en || st_ff.mode[MODE_STBY_BIT];
		// edge detector; idle level of the pin is low, as after reset
		trig_rise = LNK.trig && !st_ff.trig_q;
		nxt_st.trig_q = LNK.trig;
		fire = 1'b0;
		// a write counts only when offered and accepted
		wr_ok = LNK.wr && LNK.wvalid && LNK.wready;
		// register writes; mode holds its value until rewritten
		if (wr_ok)
		begin
			// mode select, standby bit included
			if (LNK.addr == OFS_MODE)
			begin
				nxt_st.mode = LNK.wdata;
			end
			// realtime amplitude
			if (LNK.addr == OFS_AMP)
			begin
				nxt_st.amp = LNK.wdata;
			end
			// pwm or analog selection
			if (LNK.addr == OFS_CFG)
			begin
				nxt_st.cfg = LNK.wdata;
			end
			// effect slots
			if (is_slot(LNK.addr))
			begin
				nxt_st.slot[slot_of(LNK.addr)] = LNK.wdata;
			end
			// start bit fires only in software trigger mode
			if (LNK.addr == OFS_START && LNK.wdata[START_BIT]
				&& st_ff.mode[2:0] == MD_SOFT)
			begin
				fire = 1'b1;
			end
		end
		// pin triggers
		if (st_ff.mode[2:0] == MD_EDGE && trig_rise) fire = 1'b1;
		if (st_ff.mode[2:0] == MD_LEVEL && LNK.trig) fire = 1'b1;
		if (lowp) fire = 1'b0;
		// read data one cycle later
		nxt_st.rdata = ZERO8;
		if (LNK.rd)
		begin
			case (LNK.addr)
				OFS_MODE:  nxt_st.rdata = st_ff.mode;
				OFS_AMP:   nxt_st.rdata = st_ff.amp;
				OFS_CFG:   nxt_st.rdata = st_ff.cfg;
				OFS_START: nxt_st.rdata = {7'h00, st_ff.play == HPM_PLAY};
				// slots, anything else reads as zero
				default:
				begin
					if (is_slot(LNK.addr))
					begin
						nxt_st.rdata = st_ff.slot[slot_of(LNK.addr)];
					end
				end
			endcase
		end
		// sequencer: play slots in order, stop at zero id or last slot
		case (st_ff.play)
			// idle: a trigger starts from the first slot, again and again
			HPM_IDLE:
			begin
				if (fire && st_ff.slot[0] != ZERO8)
				begin
					nxt_st.play = HPM_PLAY;
					nxt_st.idx = 3'd0;
					nxt_st.tcnt = 16'(EFF_CYC - 1);
				end
			end
			// playing: count down each slot, then step or stop
			HPM_PLAY:
			begin
				if (lowp)
				begin
					// low power cuts the sequence short
					nxt_st.play = HPM_IDLE;
				end
				else if (st_ff.tcnt != 16'd0)
				begin
					nxt_st.tcnt = st_ff.tcnt - 16'd1;
				end
				else if (st_ff.idx == 3'(NSLOT - 1) || st_ff.slot[st_ff.idx + 3'd1] == ZERO8)
				begin
					// last effect done; start bit reads zero again
					nxt_st.play = HPM_IDLE;
				end
				else
				begin
					nxt_st.idx = st_ff.idx + 3'd1;
					nxt_st.tcnt = 16'(EFF_CYC - 1);
				end
			end
			// unused code returns to idle
			default:
			begin
				nxt_st.play = HPM_IDLE;
			end
		endcase
		// output drive by mode
		nxt_st.lowp = lowp;
		nxt_st.active = 1'b0;
		nxt_st.drive = ZERO8;
		if (!lowp)
		begin
			case (st_ff.mode[2:0])
				MD_RT:
				begin
					nxt_st.drive = st_ff.amp;
					nxt_st.active = 1'b1;
				end
				MD_EXT:
				begin
					nxt_st.drive = {8{LNK.trig}};
					nxt_st.active = 1'b1;
				end
				// library modes: drive the id of the slot playing
				default:
				begin
					if (st_ff.play == HPM_PLAY)
					begin
						nxt_st.drive = st_ff.slot[st_ff.idx];
						nxt_st.active = 1'b1;
					end
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			st_ff <= '0;
			st_ff.mode <= MODE_RST;
			st_ff.lowp <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end
endmodule : hpm_dev

// File: hpm_host.sv
// controller end: takes orders over a simple port, writes device registers
// assumes device answers reads one cycle later; drives enable and trigger pins
`timescale 1ns/1ps
module hpm_host
	import hpm_pkg::*;
#(
	parameter int PWR_CYC = PWRUP_CYC
) (
	// clock and reset
	input  wire logic       CLK_I,
	input  wire logic       RESETN_I,
	// software port
	input  wire logic [3:0] SW_ADDR_I,
	input  wire logic [15:0] SW_WDATA_I,
	input  wire logic       SW_WR_I,
	input  wire logic       SW_RD_I,
	output logic [15:0]     SW_RDATA_O,
	output logic            SW_READY_O,   // buffer has room
	// pins toward the device
	input  wire logic       EN_REQ_I,
	input  wire logic       TRIG_REQ_I,
	// link
	hpm_if.host             LNK
);
	typedef struct packed {
		logic [19:0] wait_cnt;
		logic        up;
		logic        wr;
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic        en;
		logic        trig;
		logic [15:0] rdata;
	} hpm_host_t;
	hpm_host_t st_ff, nxt_st;
	logic b_valid, b_ready, pop;
	logic [15:0] b_data;
	// command words (addr,data) buffered; drained only after power-up wait
	hpm_buf2 #(.W(16)) u_buf (
		.clk_i      (CLK_I),
		.rst_n_i    (RESETN_I),
		.in_valid_i (SW_WR_I && SW_ADDR_I == CTL_ADR_CMD),
		.in_ready_o (b_ready),
		.in_data_i  (SW_WDATA_I),
		.out_valid_o(b_valid),
		.out_ready_i(pop),
		.out_data_o (b_data)
	);
	assign pop = st_ff.up && LNK.wready;
	assign LNK.en = st_ff.en;
	assign LNK.trig = st_ff.trig;
	assign LNK.addr = st_ff.addr;
	assign LNK.wdata = st_ff.wdata;
	assign LNK.wr = st_ff.wr;
	assign LNK.rd = 1'b0;
	assign LNK.wvalid = st_ff.wr;
	assign SW_RDATA_O = st_ff.rdata;
	assign SW_READY_O = b_ready;
	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.en = EN_REQ_I;
		nxt_st.trig = TRIG_REQ_I;
		if (!st_ff.up)
		begin
			if (st_ff.wait_cnt == 20'(PWR_CYC - 1)) nxt_st.up = 1'b1;
			else nxt_st.wait_cnt = st_ff.wait_cnt + 20'd1;
		end
		nxt_st.wr = b_valid && pop;
		nxt_st.addr = b_data[15:8];
		nxt_st.wdata = b_data[7:0];
		nxt_st.rdata = 16'h0000;
		if (SW_RD_I && SW_ADDR_I == CTL_ADR_STATUS)
			nxt_st.rdata = {13'h0, b_valid, st_ff.en, st_ff.up};
	end
	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule : hpm_host

// File: hpm_monitor.sv
// checker: link signals and device outputs of the playback pair
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module hpm_monitor
	import hpm_pkg::*;
#(
	parameter int PWR_CYC = PWRUP_CYC,
	parameter int EFF_CYC = EFFECT_CYC
) (
	// clock and reset
	input  wire logic       CLK_I,
	input  wire logic       RESETN_I,
	// link
	input  wire logic       en,
	input  wire logic       trig,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	// device outputs
	input  wire logic [7:0] DRIVE_O,
	input  wire logic       ACTIVE_O,
	input  wire logic       LOW_POWER_O,
	input  wire logic       ANALOG_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	localparam int SEQ_MAX = NSLOT * EFF_CYC + 2;
	logic [7:0]  mode_ff; // mode as last written on the link
	logic [15:0] up_ff;   // cycles since reset, saturating
	logic [7:0]  act_ff;  // length of the current playback
	logic        run;     // enabled and out of standby
	assign run = en && !mode_ff[MODE_STBY_BIT];
	////////////////////////////////////////////////////////////////
	// helper state tracks mode, time since reset, playback length
	always_ff @(posedge CLK_I)
	begin
		if (!RESETN_I)
		begin
			mode_ff <= MODE_RST;
			up_ff   <= '0;
			act_ff  <= '0;
		end
		else
		begin
			if (wr && addr == OFS_MODE)
				mode_ff <= wdata;
			if (up_ff != 16'hffff)
				up_ff <= up_ff + 16'h0001;
			// only library playback is bounded; realtime and external drive run freely
			if (ACTIVE_O && mode_ff[2:0] != MD_RT && mode_ff[2:0] != MD_EXT)
				act_ff <= act_ff + 8'h01;
			else
				act_ff <= 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////
	// start bit write while idle in software mode
	sequence s_go;
		wr && addr == OFS_START && wdata[START_BIT] && mode_ff[2:0] == MD_SOFT && run && !ACTIVE_O;
	endsequence
	// standby cleared with the enable pin held
	sequence s_wake;
		(wr && addr == OFS_MODE && wdata == ZERO8 && en) ##1 en ##1 en;
	endsequence
	a_power_wait: assert property (wr |-> up_ff >= PWR_CYC)
		else $error("link write before power-up wait");
	a_sw_fire: assert property (s_go |-> ##[1:4] ACTIVE_O)
		else $error("start bit did not fire playback");
	a_pin_fire: assert property ($rose(trig) && run && !ACTIVE_O
		&& (mode_ff[2:0] == MD_EDGE || mode_ff[2:0] == MD_LEVEL) |-> ##[1:4] ACTIVE_O)
		else $error("trigger pin did not fire playback");
	a_seq_len: assert property (act_ff <= SEQ_MAX)
		else $error("playback longer than eight slots");
	a_en_low: assert property (!en [*2] |-> LOW_POWER_O)
		else $error("enable low without low power");
	a_stby_set: assert property (wr && addr == OFS_MODE && wdata[MODE_STBY_BIT]
		|-> ##[1:2] LOW_POWER_O)
		else $error("standby write without low power");
	a_mode_wake: assert property (s_wake |-> !LOW_POWER_O)
		else $error("mode zero did not leave standby");
	a_rt_amp: assert property ((wr && addr == OFS_AMP && mode_ff[2:0] == MD_RT && run)
		##1 !wr [*2] |-> DRIVE_O == $past(wdata, 2))
		else $error("drive does not follow amplitude write");
	a_cfg_bit: assert property (wr && addr == OFS_CFG
		|-> ##2 ANALOG_O == $past(wdata[CFG_ANALOG_BIT], 2))
		else $error("analog select does not follow config");
	a_ext_drive: assert property ((mode_ff[2:0] == MD_EXT && run && trig) [*3]
		|-> DRIVE_O == 8'hff)
		else $error("external input not driven through");
endmodule : hpm_monitor

// File: haptic_playback_mode_control_tb_top.sv
// testbench: host and device joined by the link, software port driven
// assumes shortened power-up wait and effect time
`timescale 1ns/1ps
module haptic_playback_mode_control_tb_top
	import hpm_pkg::*;
;
	logic        CLK_I, RESETN_I, sw_wr, sw_rd, en_req, trig_req, sw_ready;
	logic        active, low_power, analog;
	logic [3:0]  sw_addr;
	logic [15:0] sw_wdata, sw_rdata;
	logic [7:0]  drive, prev, amp;
	logic [7:0]  id [3];
	logic [7:0]  exp_q [$]; // expected drive values in order
	int          n_errors, samples_checked, i, k, seed;
	hpm_if lnk();
	hpm_host #(.PWR_CYC(10)) u_hpm_host (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
		.SW_ADDR_I(sw_addr), .SW_WDATA_I(sw_wdata), .SW_WR_I(sw_wr), .SW_RD_I(sw_rd),
		.SW_RDATA_O(sw_rdata), .SW_READY_O(sw_ready), .EN_REQ_I(en_req),
		.TRIG_REQ_I(trig_req), .LNK(lnk.host));
	hpm_dev #(.EFF_CYC(4)) u_hpm_dev (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .LNK(lnk.dev),
		.DRIVE_O(drive), .ACTIVE_O(active), .LOW_POWER_O(low_power), .ANALOG_O(analog));
	hpm_monitor #(.PWR_CYC(10), .EFF_CYC(4)) u_hpm_monitor (.CLK_I(CLK_I),
		.RESETN_I(RESETN_I), .en(lnk.en), .trig(lnk.trig), .addr(lnk.addr),
		.wdata(lnk.wdata), .wr(lnk.wr), .DRIVE_O(drive), .ACTIVE_O(active),
		.LOW_POWER_O(low_power), .ANALOG_O(analog));
	initial
	begin
		CLK_I = 1'b0;
		forever #10 CLK_I = ~CLK_I;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one command write once the buffer has room, then n idle cycles
	task automatic cmd(input logic [7:0] a, input logic [7:0] d, input int n);
		for (int w = 0; w < 50 && sw_ready !== 1'b1; w++)
			@(posedge CLK_I);
		sw_addr  <= CTL_ADR_CMD;
		sw_wdata <= {a, d};
		sw_wr    <= 1'b1;
		@(posedge CLK_I);
		sw_wr <= 1'b0;
		repeat (n) @(posedge CLK_I);
	endtask : cmd
	// bounded wait for the playback flag
	task automatic wact(input logic v);
		for (int w = 0; w < 200 && active !== v; w++)
			@(posedge CLK_I);
		chk("active", {7'h0, v}, {7'h0, active});
	endtask : wact
	// status read: strobe one cycle, data stands in the cycle after it
	task automatic rds(input logic [15:0] e);
		sw_addr <= CTL_ADR_STATUS;
		sw_rd   <= 1'b1;
		@(posedge CLK_I);
		sw_rd   <= 1'b0;
		@(posedge CLK_I);
		chk("status_hi", e[15:8], sw_rdata[15:8]);
		chk("status_lo", e[7:0], sw_rdata[7:0]);
	endtask : rds
	task automatic finish_test();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// watcher: each new nonzero drive value takes the oldest note
	always @(posedge CLK_I)
	begin
		if (RESETN_I === 1'b1 && drive !== prev && drive !== 8'h00)
			chk("drive", exp_q.size() > 0 ? exp_q.pop_front() : 8'h00, drive);
		prev <= drive;
	end
	initial
	begin
		#80000;
		n_errors++;
		$display("MISMATCH watchdog expected end seen hang");
		finish_test();
	end
	initial
	begin
		seed = 32'h2a4328ff;
		n_errors = 0;
		samples_checked = 0;
		{RESETN_I, sw_wr, sw_rd, en_req, trig_req, sw_addr, sw_wdata} = '0;
		repeat (2) @(posedge CLK_I);
		RESETN_I <= 1'b1;
		@(posedge CLK_I);
		chk("low_power", 8'h01, {7'h0, low_power});
		// fill the buffer during the power-up wait
		sw_wdata <= {OFS_MODE, ZERO8};
		sw_wr    <= 1'b1;
		@(posedge CLK_I);
		sw_wdata <= {OFS_CFG, ZERO8};
		en_req   <= 1'b1;
		@(posedge CLK_I);
		sw_wr <= 1'b0;
		@(posedge CLK_I);
		chk("ready", 8'h00, {7'h0, sw_ready});
		rds(16'h0006);
		repeat (14) @(posedge CLK_I);
		chk("low_power", 8'h00, {7'h0, low_power});
		for (i = 0; i < 3; i++)
		begin
			id[i] = {i[1:0] + 2'd1, 6'($random(seed))};
			cmd(OFS_SLOT0 + 8'(i), id[i], 1);
		end
		cmd(OFS_SLOT0 + 8'h03, ZERO8, 4);
		// software start twice, then edge and level trigger
		for (k = 0; k < 4; k++)
		begin
			if (k > 1)
				cmd(OFS_MODE, {5'h0, 3'(k - 1)}, 4);
			for (i = 0; i < 3; i++)
				exp_q.push_back(id[i]);
			if (k < 2)
				cmd(OFS_START, 8'h01, 1);
			else
			begin
				trig_req <= 1'b1;
				repeat (2) @(posedge CLK_I);
				trig_req <= 1'b0;
			end
			wact(1'b1);
			wact(1'b0);
		end
		cmd(OFS_MODE, {5'h0, MD_RT}, 4);
		for (i = 0; i < 3; i++)
		begin
			amp = {i[1:0] + 2'd1, 6'($random(seed))};
			exp_q.push_back(amp);
			cmd(OFS_AMP, amp, 4);
		end
		cmd(OFS_CFG, 8'h02, 1);
		cmd(OFS_MODE, {5'h0, MD_EXT}, 4);
		chk("analog", 8'h01, {7'h0, analog});
		exp_q.push_back(8'hff);
		trig_req <= 1'b1;
		repeat (6) @(posedge CLK_I);
		trig_req <= 1'b0;
		cmd(OFS_MODE, 8'h43, 4);
		chk("low_power", 8'h01, {7'h0, low_power});
		en_req <= 1'b0;
		cmd(OFS_MODE, {5'h0, MD_EXT}, 4);
		chk("low_power", 8'h01, {7'h0, low_power});
		rds(16'h0001);
		chk("pending", 8'h00, 8'(exp_q.size()));
		finish_test();
	end
endmodule : haptic_playback_mode_control_tb_top
